// ### rtl/osdsh_device.sv
`timescale 1ns/10ps
`default_nettype none
module osdsh_device
  import osdsh_pkg::*;
(
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  osdsh_link_if.device     LINK,
  input  wire logic        WIN_ACT_I,
  input  wire logic [2:0]  WIN_COLOR_I,
  input  wire logic [3:0]  WIN_SHADOW_I,
  input  wire logic        EDGE_I,
  input  wire logic        CHAR_LUM_I,
  input  wire logic [2:0]  CHAR_COLOR_I,
  output logic      [2:0]  RGB_O,
  output logic             FAST_BLANK_O,
  output logic      [15:0] SHADOW_WIDTH_O,
  output logic      [15:0] SHADOW_HEIGHT_O,
  output logic             PANEL_MODE_O,
  output logic             SELFTEST_O
);

  typedef struct packed {
    logic [4:0]  count;
    logic [23:0] shift;
    logic [23:0] word;
    logic        full;
  } osdsh_link_t;

  typedef struct packed {
    logic                             sync1;
    logic                             sync2;
    logic                             sync3;
    logic [2:0]                       char_edge_color_field;
    logic                             selftest_enable;
    logic [2:0]                       selftest_color;
    logic [7:0]                       shadow_width_codes;
    logic [7:0]                       shadow_height_codes;
    logic [3:0]                       window_shadow_enable;
    logic [2:0]                       win1_shadow_color;
    logic [2:0]                       win2_shadow_color;
    logic [2:0]                       win3_shadow_color;
    logic [2:0]                       win4_shadow_color;
    logic [2:0]                       output_delay_code;
    logic                             panel_mode_select;
    logic [5:0]                       mode_unlock_key;
    logic [DELAY_STAGES-1:0][3:0]     pipe;
    logic [3:0]                       video;
  } osdsh_core_t;

  osdsh_link_t lnk_ff;
  osdsh_link_t nxt_lnk;
  osdsh_core_t core_ff;
  osdsh_core_t nxt_core;

  // Link side: bits are taken on the rising link clock while selected.
  // The clock stands still between frames, so the frame counter is
  // cleared by the closing edge the host gives with select released.
  always_comb
  begin
    nxt_lnk = lnk_ff;
    if (LINK.cs_n)
    begin
      nxt_lnk.count = 5'h00;
    end
    else
    begin
      nxt_lnk.shift = {lnk_ff.shift[22:0], LINK.sda};
      nxt_lnk.full  = 1'b0;
      if (lnk_ff.count == FRAME_BITS - 5'h01)
      begin
        nxt_lnk.word   = {lnk_ff.shift[22:0], LINK.sda};
        nxt_lnk.full   = 1'b1;
        nxt_lnk.count  = 5'h00;
      end
      else
      begin
        nxt_lnk.count = lnk_ff.count + 5'h01;
      end
    end
  end

  always_ff @(posedge LINK.sck)
  begin
    lnk_ff <= nxt_lnk;
  end

  function automatic osdsh_core_t core_defaults(input osdsh_core_t keep);
    osdsh_core_t d;
    d                       = keep;
    d.char_edge_color_field = RST_COLOR;
    d.selftest_enable       = 1'b0;
    d.selftest_color        = RST_COLOR;
    d.shadow_width_codes    = RST_CODES;
    d.shadow_height_codes   = RST_CODES;
    d.window_shadow_enable  = RST_SHADOW;
    d.win1_shadow_color     = RST_COLOR;
    d.win2_shadow_color     = RST_COLOR;
    d.win3_shadow_color     = RST_COLOR;
    d.win4_shadow_color     = RST_COLOR;
    d.output_delay_code     = RST_DELAY;
    d.pipe                  = '0;
    d.video                 = 4'h0;
    return d;
  endfunction

  function automatic logic [3:0] shadow_size(input logic [1:0] code);
    return SHADOW_BASE + 4'({code, 1'b0});
  endfunction

  logic       wr_strobe;
  logic [7:0] wr_row;
  logic [7:0] wr_col;
  logic [7:0] wr_data;
  logic [2:0] shadow_pick;
  logic       shadow_hit;
  logic [3:0] encoded;

  // The word stands from its last bit to the next frame's last bit, so
  // it is safe to read once the full flag has passed the synchroniser.
  assign wr_strobe = core_ff.sync2 & ~core_ff.sync3;
  assign wr_row    = lnk_ff.word[23:16];
  assign wr_col    = lnk_ff.word[15:8];
  assign wr_data   = lnk_ff.word[7:0];

  // Window 1 wins over later windows where shadows overlap
  always_comb
  begin
    logic [11:0] colors;
    colors      = {core_ff.win4_shadow_color, core_ff.win3_shadow_color,
                   core_ff.win2_shadow_color, core_ff.win1_shadow_color};
    shadow_pick = 3'h0;
    shadow_hit  = 1'b0;
    for (int w = 3; w >= 0; w--)
    begin
      if (WIN_SHADOW_I[w] && core_ff.window_shadow_enable[w])
      begin
        shadow_pick = colors[w*3 +: 3];
        shadow_hit  = 1'b1;
      end
    end
  end

  // Colour encoder; fast blank is the top bit
  always_comb
  begin
    if (core_ff.selftest_enable)
    begin
      encoded = {1'b1, core_ff.selftest_color};
    end
    else if (EDGE_I)
    begin
      encoded = {1'b1, core_ff.char_edge_color_field};
    end
    else if (CHAR_LUM_I)
    begin
      encoded = {1'b1, CHAR_COLOR_I};
    end
    else if (shadow_hit)
    begin
      encoded = {1'b1, shadow_pick};
    end
    else if (WIN_ACT_I)
    begin
      encoded = {1'b1, WIN_COLOR_I};
    end
    else
    begin
      encoded = 4'h0;
    end
  end

  always_comb
  begin
    nxt_core       = core_ff;
    nxt_core.sync1 = lnk_ff.full;
    nxt_core.sync2 = core_ff.sync1;
    nxt_core.sync3 = core_ff.sync2;
    nxt_core.pipe  = {core_ff.pipe[DELAY_STAGES-2:0], encoded};
    // CRT mode ignores the delay code and takes the shortest path
    if (core_ff.panel_mode_select)
    begin
      nxt_core.video = core_ff.pipe[core_ff.output_delay_code];
    end
    else
    begin
      nxt_core.video = core_ff.pipe[0];
    end
    if (wr_strobe && wr_row == ROW_MAIN)
    begin
      case (wr_col)
        COL_EDGE_COLOR:
          nxt_core.char_edge_color_field = wr_data[2:0];
        COL_SELFTEST:
        begin
          nxt_core.selftest_enable = wr_data[SELFTEST_EN_BIT];
          nxt_core.selftest_color  = wr_data[2:0];
        end
        COL_SHADOW_W:
          nxt_core.shadow_width_codes = wr_data;
        COL_SHADOW_H:
          nxt_core.shadow_height_codes = wr_data;
        COL_WIN1_CTRL:
          nxt_core.window_shadow_enable[0] = wr_data[SHADOW_EN_BIT];
        COL_WIN2_CTRL:
          nxt_core.window_shadow_enable[1] = wr_data[SHADOW_EN_BIT];
        COL_WIN3_CTRL:
          nxt_core.window_shadow_enable[2] = wr_data[SHADOW_EN_BIT];
        COL_WIN4_CTRL:
          nxt_core.window_shadow_enable[3] = wr_data[SHADOW_EN_BIT];
        default:
          nxt_core.selftest_enable = core_ff.selftest_enable;
      endcase
    end
    else if (wr_strobe && wr_row == ROW_EXT)
    begin
      case (wr_col)
        COL_SHADOW_CA:
        begin
          nxt_core.win1_shadow_color = wr_data[COLOR_HI_LSB +: 3];
          nxt_core.win2_shadow_color = wr_data[2:0];
        end
        COL_SHADOW_CB:
        begin
          nxt_core.win3_shadow_color = wr_data[COLOR_HI_LSB +: 3];
          nxt_core.win4_shadow_color = wr_data[2:0];
        end
        COL_OUT_DELAY:
          nxt_core.output_delay_code = wr_data[2:0];
        COL_APP_SELECT:
        begin
          nxt_core.mode_unlock_key = wr_data[5:0];
          // A wrong key leaves the mode alone; the key bits still store
          if ((wr_data[PANEL_MODE_BIT] && wr_data[5:0] == KEY_TO_LCD) ||
              (!wr_data[PANEL_MODE_BIT] && wr_data[5:0] == KEY_TO_CRT))
          begin
            nxt_core.panel_mode_select = wr_data[PANEL_MODE_BIT];
          end
          if (nxt_core.panel_mode_select != core_ff.panel_mode_select)
          begin
            nxt_core = core_defaults(nxt_core);
          end
        end
        default:
          nxt_core.panel_mode_select = core_ff.panel_mode_select;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      core_ff       <= '0;
      core_ff.sync1 <= 1'b1;
      core_ff.sync2 <= 1'b1;
      core_ff.sync3 <= 1'b1;
    end
    else if (CE_I)
    begin
      core_ff <= nxt_core;
    end
  end

  for (genvar w = 0; w < 4; w++)
  begin : g_shadow
    assign SHADOW_WIDTH_O[w*4 +: 4] = core_ff.window_shadow_enable[w] ?
      shadow_size(core_ff.shadow_width_codes[w*2 +: 2]) : 4'h0;
    assign SHADOW_HEIGHT_O[w*4 +: 4] = core_ff.window_shadow_enable[w] ?
      shadow_size(core_ff.shadow_height_codes[w*2 +: 2]) : 4'h0;
  end

  assign RGB_O        = core_ff.video[2:0];
  assign FAST_BLANK_O = core_ff.video[3];
  assign PANEL_MODE_O = core_ff.panel_mode_select;
  assign SELFTEST_O   = core_ff.selftest_enable;

endmodule // osdsh_device
`default_nettype wire

// ### rtl/osdsh_pkg.sv
`default_nettype none
package osdsh_pkg;

  // Memory map rows and columns
  localparam logic [7:0] ROW_MAIN       = 8'h0f;
  localparam logic [7:0] ROW_EXT        = 8'h10;
  localparam logic [7:0] COL_WIN1_CTRL  = 8'h01;
  localparam logic [7:0] COL_WIN2_CTRL  = 8'h04;
  localparam logic [7:0] COL_WIN3_CTRL  = 8'h07;
  localparam logic [7:0] COL_WIN4_CTRL  = 8'h0a;
  localparam logic [7:0] COL_LINE_RES   = 8'h0f;
  localparam logic [7:0] COL_DISP_CTRL  = 8'h11;
  localparam logic [7:0] COL_SYNC_CTRL  = 8'h12;
  localparam logic [7:0] COL_EDGE_COLOR = 8'h13;
  localparam logic [7:0] COL_SELFTEST   = 8'h14;
  localparam logic [7:0] COL_SHADOW_W   = 8'h15;
  localparam logic [7:0] COL_SHADOW_H   = 8'h16;
  localparam logic [7:0] COL_RSV_FIRST  = 8'h17;
  localparam logic [7:0] COL_SHADOW_CA  = 8'h00;
  localparam logic [7:0] COL_SHADOW_CB  = 8'h01;
  localparam logic [7:0] COL_OUT_DELAY  = 8'h02;
  localparam logic [7:0] COL_RSV_EXT    = 8'h03;
  localparam logic [7:0] COL_APP_SELECT = 8'h04;

  // Field positions
  localparam int SHADOW_EN_BIT     = 1;
  localparam int SELFTEST_EN_BIT   = 7;
  localparam int PANEL_MODE_BIT    = 7;
  localparam int COLOR_HI_LSB      = 4;
  localparam int LINE_RES_W        = 7;

  // Unlock keys for the panel mode bit
  localparam logic [5:0] KEY_TO_LCD = 6'h15;
  localparam logic [5:0] KEY_TO_CRT = 6'h2a;

  // Reset values
  localparam logic [2:0] RST_COLOR    = 3'h0;
  localparam logic [7:0] RST_CODES    = 8'h00;
  localparam logic [3:0] RST_SHADOW   = 4'h0;
  localparam logic [2:0] RST_DELAY    = 3'h0;
  localparam logic [6:0] RST_LINE_RES = 7'h28;

  // Shadow size decode: code 0..3 gives 2,4,6,8
  localparam logic [3:0] SHADOW_BASE = 4'h2;

  // VCO band edges in kHz of pixel rate
  localparam logic [19:0] VCO_EDGE_0 = 20'd28000;
  localparam logic [19:0] VCO_EDGE_1 = 20'd56000;
  localparam logic [19:0] VCO_EDGE_2 = 20'd112000;
  localparam logic [19:0] DOTS_PER_STEP = 20'd12;

  // Link framing and timing
  localparam logic [4:0] FRAME_BITS  = 5'd24;
  localparam int         CLK_MHZ     = 250;
  localparam int         LINK_NS     = 64;
  localparam logic [3:0] SCK_HALF    = 4'(LINK_NS * CLK_MHZ / 2000);
  localparam int         PLL_SETTLE_US      = 1000;
  localparam int         SETTLE_CYCLES_DEF  = PLL_SETTLE_US * CLK_MHZ;
  localparam int         DELAY_STAGES       = 8;

  typedef enum logic [2:0] {
    H_IDLE,
    H_LOW,
    H_HIGH,
    H_CLOSE_LOW,
    H_CLOSE_HIGH,
    H_GAP
  } osdsh_host_st_t;

endpackage
`default_nettype wire

// ### rtl/osdsh_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface osdsh_link_if;
  logic cs_n;
  logic sck;
  logic sda;

  modport host
  (
    output cs_n,
    output sck,
    output sda
  );

  modport device
  (
    input cs_n,
    input sck,
    input sda
  );
endinterface // osdsh_link_if
`default_nettype wire

// ### rtl/osdsh_host.sv
`timescale 1ns/10ps
`default_nettype none
module osdsh_host
  import osdsh_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF
)
(
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  osdsh_link_if.host       LINK,
  input  wire logic        WR_VALID_I,
  output logic             WR_READY_O,
  input  wire logic [7:0]  WR_ROW_I,
  input  wire logic [7:0]  WR_COL_I,
  input  wire logic [7:0]  WR_DATA_I,
  output logic             WR_REJECT_O,
  input  wire logic [7:0]  HFREQ_KHZ_I,
  input  wire logic        HSYNC_CHANGE_I,
  output logic             PLL_SETTLED_O,
  output logic      [1:0]  VCO_CODE_O
);

  typedef struct packed {
    osdsh_host_st_t  st;
    logic [3:0]      div;
    logic [4:0]      bits;
    logic [23:0]     shift;
    logic            cs_n;
    logic            sck;
    logic            sda;
    logic [19:0]     settle;
    logic [6:0]      line_resolution;
    logic [1:0]      vco_range_code;
    logic            reject;
  } osdsh_host_state_t;

  osdsh_host_state_t h_ff;
  osdsh_host_state_t nxt_h;

  function automatic logic [1:0] vco_band(input logic [19:0] px_khz);
    if (px_khz <= VCO_EDGE_0)
      return 2'h0;
    else if (px_khz <= VCO_EDGE_1)
      return 2'h1;
    else if (px_khz <= VCO_EDGE_2)
      return 2'h2;
    else
      return 2'h3;
  endfunction

  logic [19:0] pixel_khz;
  logic [1:0]  code_now;
  logic        settled;
  logic        pll_safe_col;
  logic        reserved;
  logic        allowed;
  logic        half_done;

  assign pixel_khz = 20'(HFREQ_KHZ_I) * 20'(h_ff.line_resolution) * DOTS_PER_STEP;
  assign code_now  = vco_band(pixel_khz);
  assign settled   = (h_ff.settle == 20'h0);
  assign pll_safe_col = (WR_ROW_I == ROW_MAIN) && (WR_COL_I == COL_LINE_RES ||
                        WR_COL_I == COL_DISP_CTRL || WR_COL_I == COL_SYNC_CTRL);
  // Columns 23..31 include the test byte at 31
  assign reserved  = (WR_ROW_I == ROW_MAIN && WR_COL_I >= COL_RSV_FIRST) ||
                     (WR_ROW_I == ROW_EXT && WR_COL_I == COL_RSV_EXT);
  assign allowed   = !reserved && (settled || pll_safe_col);
  assign half_done = (h_ff.div == SCK_HALF - 4'h1);

  always_comb
  begin
    nxt_h        = h_ff;
    nxt_h.reject = 1'b0;
    if (!settled)
    begin
      nxt_h.settle = h_ff.settle - 20'h1;
    end
    if (HSYNC_CHANGE_I)
    begin
      nxt_h.settle = 20'(SETTLE_CYCLES);
    end
    nxt_h.div = half_done ? 4'h0 : h_ff.div + 4'h1;
    case (h_ff.st)
      H_IDLE:
      begin
        nxt_h.div = 4'h0;
        if (WR_VALID_I && !allowed)
        begin
          nxt_h.reject = 1'b1;
        end
        else if (WR_VALID_I)
        begin
          nxt_h.shift = {WR_ROW_I, WR_COL_I, WR_DATA_I};
          if (WR_ROW_I == ROW_MAIN && WR_COL_I == COL_SYNC_CTRL)
          begin
            // VCO bits are always replaced by the computed band
            nxt_h.shift[1:0]      = code_now;
            nxt_h.vco_range_code = code_now;
            if (code_now != h_ff.vco_range_code)
            begin
              nxt_h.settle = 20'(SETTLE_CYCLES);
            end
          end
          if (WR_ROW_I == ROW_MAIN && WR_COL_I == COL_LINE_RES)
          begin
            nxt_h.line_resolution = WR_DATA_I[LINE_RES_W-1:0];
            nxt_h.settle          = 20'(SETTLE_CYCLES);
          end
          nxt_h.cs_n = 1'b0;
          nxt_h.sda  = WR_ROW_I[7];
          nxt_h.bits = 5'h00;
          nxt_h.st   = H_LOW;
        end
      end
      H_LOW:
        if (half_done)
        begin
          nxt_h.sck = 1'b1;
          nxt_h.st  = H_HIGH;
        end
      H_HIGH:
        if (half_done)
        begin
          nxt_h.sck = 1'b0;
          if (h_ff.bits == FRAME_BITS - 5'h01)
          begin
            nxt_h.cs_n = 1'b1;
            nxt_h.st   = H_CLOSE_LOW;
          end
          else
          begin
            nxt_h.bits  = h_ff.bits + 5'h01;
            nxt_h.shift = {h_ff.shift[22:0], 1'b0};
            nxt_h.sda   = h_ff.shift[22];
            nxt_h.st    = H_LOW;
          end
        end
      H_CLOSE_LOW:
        if (half_done)
        begin
          nxt_h.sck = 1'b1;
          nxt_h.st  = H_CLOSE_HIGH;
        end
      H_CLOSE_HIGH:
        if (half_done)
        begin
          nxt_h.sck = 1'b0;
          nxt_h.st  = H_GAP;
        end
      H_GAP:
        if (half_done)
        begin
          nxt_h.st = H_IDLE;
        end
      default:
        nxt_h.st = H_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      h_ff                 <= '0;
      // A closing edge first clears the link bit counter
      h_ff.st              <= H_CLOSE_LOW;
      h_ff.cs_n            <= 1'b1;
      h_ff.line_resolution <= RST_LINE_RES;
    end
    else if (CE_I)
    begin
      h_ff <= nxt_h;
    end
  end

  assign WR_READY_O    = (h_ff.st == H_IDLE) && allowed && CE_I;
  assign WR_REJECT_O   = h_ff.reject;
  assign PLL_SETTLED_O = settled;
  assign VCO_CODE_O    = h_ff.vco_range_code;
  assign LINK.cs_n     = h_ff.cs_n;
  assign LINK.sck      = h_ff.sck;
  assign LINK.sda      = h_ff.sda;

endmodule // osdsh_host
`default_nettype wire

// ### testbench/osdsh_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module osdsh_assertions
  import osdsh_pkg::*;
(
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        cs_n,
  input  wire logic        WR_VALID_I,
  input  wire logic        WR_READY_O,
  input  wire logic        WR_REJECT_O,
  input  wire logic [7:0]  WR_ROW_I,
  input  wire logic [7:0]  WR_COL_I,
  input  wire logic        HSYNC_CHANGE_I,
  input  wire logic        PLL_SETTLED_O,
  input  wire logic        FAST_BLANK_O,
  input  wire logic [15:0] SHADOW_WIDTH_O,
  input  wire logic [15:0] SHADOW_HEIGHT_O,
  input  wire logic        PANEL_MODE_O,
  input  wire logic        SELFTEST_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  // Cycles since the last frame; saturates so it never wraps into a false match
  logic [5:0] idle_ff;
  logic [5:0] nxt_idle;
  logic       main_ok;
  logic       rsv_hit;

  assign main_ok = WR_ROW_I == ROW_MAIN
                   && WR_COL_I inside {COL_LINE_RES, COL_DISP_CTRL, COL_SYNC_CTRL};
  assign rsv_hit = (WR_ROW_I == ROW_MAIN && WR_COL_I >= COL_RSV_FIRST)
                   || (WR_ROW_I == ROW_EXT && WR_COL_I == COL_RSV_EXT);
  assign nxt_idle = !cs_n ? 6'h00 : (idle_ff == 6'h3f ? idle_ff : idle_ff + 6'h01);

  always_ff @(posedge CLOCK_I)
    idle_ff <= RST_I ? 6'h3f : nxt_idle;

  function automatic logic sizes_ok(input logic [15:0] v);
    sizes_ok = 1'b1;
    for (int i = 0; i < 4; i++)
      if (v[4*i] || v[4*i+:4] > 4'h8)
        sizes_ok = 1'b0;
  endfunction

  // Ten cycles covers the longest PANEL_MODE_SELECT delay path
  sequence s_selftest_held;
    SELFTEST_O [*8] ##1 SELFTEST_O [*2];
  endsequence
  sequence s_mode_flip;
    $changed(PANEL_MODE_O);
  endsequence

  property p_selftest_blank;
    s_selftest_held |-> FAST_BLANK_O;
  endproperty
  property p_width_legal;
    sizes_ok(SHADOW_WIDTH_O);
  endproperty
  property p_height_legal;
    sizes_ok(SHADOW_HEIGHT_O);
  endproperty
  property p_mode_after_frame;
    s_mode_flip |-> idle_ff < 6'h10;
  endproperty
  property p_soft_reset;
    s_mode_flip |-> ##[0:4] (SHADOW_WIDTH_O == 16'h0 && SHADOW_HEIGHT_O == 16'h0
                             && !SELFTEST_O);
  endproperty
  property p_reject_pulse;
    WR_REJECT_O |-> $past(WR_VALID_I) && !$past(WR_READY_O);
  endproperty
  property p_reserved_refused;
    WR_VALID_I && rsv_hit |-> !WR_READY_O;
  endproperty
  property p_unsettled_refused;
    WR_VALID_I && !PLL_SETTLED_O && !main_ok |-> !WR_READY_O;
  endproperty
  property p_sync_unsettles;
    HSYNC_CHANGE_I |=> ##[0:3] !PLL_SETTLED_O;
  endproperty

  a_selftest_blank: assert property (p_selftest_blank)
    else $error("fast blank low during self-test");
  a_width_legal: assert property (p_width_legal)
    else $error("shadow width not 0,2,4,6,8");
  a_height_legal: assert property (p_height_legal)
    else $error("shadow height not 0,2,4,6,8");
  a_mode_after_frame: assert property (p_mode_after_frame)
    else $error("panel mode moved without a frame");
  a_soft_reset: assert property (p_soft_reset)
    else $error("mode change did not clear state");
  a_reject_pulse: assert property (p_reject_pulse)
    else $error("reject without held refused request");
  a_reserved_refused: assert property (p_reserved_refused)
    else $error("reserved location accepted");
  a_unsettled_refused: assert property (p_unsettled_refused)
    else $error("write accepted while pll unsettled");
  a_sync_unsettles: assert property (p_sync_unsettles)
    else $error("sync change did not start settling");
endmodule // osdsh_assertions
`default_nettype wire

// ### testbench/osd_shadow_selftest_mode_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
module osd_shadow_selftest_mode_regs_test
  import osdsh_pkg::*;
;
  logic        CLOCK_I = 1'b0;
  logic        RST_I = 1'b1;
  logic        WR_VALID_I = 1'b0;
  logic [7:0]  WR_ROW_I = 8'h00;
  logic [7:0]  WR_COL_I = 8'h00;
  logic [7:0]  WR_DATA_I = 8'h00;
  logic [7:0]  HFREQ_KHZ_I = 8'h40;
  logic        HSYNC_CHANGE_I = 1'b0;
  logic        WIN_ACT_I = 1'b0;
  logic [2:0]  WIN_COLOR_I = 3'h0;
  logic [3:0]  WIN_SHADOW_I = 4'h0;
  logic        EDGE_I = 1'b0;
  logic        CHAR_LUM_I = 1'b0;
  logic [2:0]  CHAR_COLOR_I = 3'h0;
  logic        WR_READY_O, WR_REJECT_O, PLL_SETTLED_O, FAST_BLANK_O;
  logic        PANEL_MODE_O, SELFTEST_O;
  logic [1:0]  VCO_CODE_O;
  logic [2:0]  RGB_O;
  logic [15:0] SHADOW_WIDTH_O, SHADOW_HEIGHT_O;
  int          error_cnt = 0;
  int          total_checks = 0;
  logic [7:0]  m_main [32];
  logic [7:0]  m_ext [8];
  logic        m_mode = 1'b0;

  osdsh_link_if link_if ();
  // Short settle count keeps the run small
  osdsh_host #(.SETTLE_CYCLES(50)) i_osdsh_host (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
    .CE_I(1'b1), .LINK(link_if), .WR_VALID_I(WR_VALID_I), .WR_READY_O(WR_READY_O),
    .WR_ROW_I(WR_ROW_I), .WR_COL_I(WR_COL_I), .WR_DATA_I(WR_DATA_I),
    .WR_REJECT_O(WR_REJECT_O), .HFREQ_KHZ_I(HFREQ_KHZ_I), .HSYNC_CHANGE_I(HSYNC_CHANGE_I),
    .PLL_SETTLED_O(PLL_SETTLED_O), .VCO_CODE_O(VCO_CODE_O));
  osdsh_device i_osdsh_device (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(1'b1),
    .LINK(link_if), .WIN_ACT_I(WIN_ACT_I), .WIN_COLOR_I(WIN_COLOR_I),
    .WIN_SHADOW_I(WIN_SHADOW_I), .EDGE_I(EDGE_I), .CHAR_LUM_I(CHAR_LUM_I),
    .CHAR_COLOR_I(CHAR_COLOR_I), .RGB_O(RGB_O), .FAST_BLANK_O(FAST_BLANK_O),
    .SHADOW_WIDTH_O(SHADOW_WIDTH_O), .SHADOW_HEIGHT_O(SHADOW_HEIGHT_O),
    .PANEL_MODE_O(PANEL_MODE_O), .SELFTEST_O(SELFTEST_O));
  osdsh_assertions i_osdsh_assertions (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
    .cs_n(link_if.cs_n), .WR_VALID_I(WR_VALID_I), .WR_READY_O(WR_READY_O),
    .WR_REJECT_O(WR_REJECT_O), .WR_ROW_I(WR_ROW_I), .WR_COL_I(WR_COL_I),
    .HSYNC_CHANGE_I(HSYNC_CHANGE_I), .PLL_SETTLED_O(PLL_SETTLED_O),
    .FAST_BLANK_O(FAST_BLANK_O), .SHADOW_WIDTH_O(SHADOW_WIDTH_O),
    .SHADOW_HEIGHT_O(SHADOW_HEIGHT_O), .PANEL_MODE_O(PANEL_MODE_O),
    .SELFTEST_O(SELFTEST_O));

  always #2 CLOCK_I = ~CLOCK_I;

  function automatic logic [15:0] m_sizes(input logic [7:0] codes);
    for (int w = 0; w < 4; w++)
      m_sizes[4*w+:4] = m_main[1+3*w][SHADOW_EN_BIT] ? 4'(2 + 2 * codes[2*w+:2]) : 4'h0;
  endfunction

  // Returns {fast blank, rgb}
  function automatic logic [3:0] m_video();
    if (m_main[COL_SELFTEST][SELFTEST_EN_BIT])
      return {1'b1, m_main[COL_SELFTEST][2:0]};
    if (EDGE_I)
      return {1'b1, m_main[COL_EDGE_COLOR][2:0]};
    if (CHAR_LUM_I)
      return {1'b1, CHAR_COLOR_I};
    for (int w = 0; w < 4; w++)
      if (WIN_SHADOW_I[w] && m_main[1+3*w][SHADOW_EN_BIT])
        return {1'b1, 3'(m_ext[w/2] >> (w[0] ? 0 : 4))};
    if (WIN_ACT_I)
      return {1'b1, WIN_COLOR_I};
    return 4'h0;
  endfunction

  task automatic m_apply(input logic [7:0] r, input logic [7:0] c, input logic [7:0] d);
    if (r == ROW_MAIN)
      m_main[c[4:0]] = d;
    else if (c == COL_APP_SELECT && d[7] != m_mode
             && d[5:0] === (d[7] ? KEY_TO_LCD : KEY_TO_CRT))
    begin
      m_mode = d[7];
      foreach (m_main[i]) m_main[i] = 8'h00;
      foreach (m_ext[i]) m_ext[i] = 8'h00;
    end
    else if (c != COL_APP_SELECT)
      m_ext[c[2:0]] = d;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_hi(input string nm, ref logic sig);
    int n;
    n = 0;
    @(negedge CLOCK_I);
    while (sig !== 1'b1 && n < 1000)
    begin
      @(negedge CLOCK_I);
      n++;
    end
    if (n == 1000)
    begin
      check(nm, 16'h1, 16'h0);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] c, input logic [7:0] d);
    @(posedge CLOCK_I);
    WR_VALID_I <= 1'b1;
    WR_ROW_I <= r;
    WR_COL_I <= c;
    WR_DATA_I <= d;
    wait_hi("write taken", WR_READY_O);
    @(posedge CLOCK_I);
    WR_VALID_I <= 1'b0;
    m_apply(r, c, d);
    wait_hi("write done", WR_READY_O);
  endtask

  task automatic refuse(input logic [7:0] r, input logic [7:0] c);
    int rej;
    rej = 0;
    @(posedge CLOCK_I);
    WR_VALID_I <= 1'b1;
    WR_ROW_I <= r;
    WR_COL_I <= c;
    repeat (4)
    begin
      @(negedge CLOCK_I);
      check("refused ready", 16'h0, {15'h0, WR_READY_O});
      rej += int'(WR_REJECT_O === 1'b1);
    end
    @(posedge CLOCK_I);
    WR_VALID_I <= 1'b0;
    check("reject pulse", 16'h1, {15'h0, rej > 0});
  endtask

  task automatic sync_pulse();
    @(posedge CLOCK_I);
    HSYNC_CHANGE_I <= 1'b1;
    @(posedge CLOCK_I);
    HSYNC_CHANGE_I <= 1'b0;
  endtask

  task automatic chk_all();
    check("width", m_sizes(m_main[COL_SHADOW_W]), SHADOW_WIDTH_O);
    check("height", m_sizes(m_main[COL_SHADOW_H]), SHADOW_HEIGHT_O);
    check("mode", {15'h0, m_mode}, {15'h0, PANEL_MODE_O});
    check("selftest", {15'h0, m_main[COL_SELFTEST][7]}, {15'h0, SELFTEST_O});
  endtask

  // Held twelve cycles so the longest PANEL_MODE_SELECT delay has settled
  task automatic vid(input int n, input logic [1:0] hi, input int lat = 2);
    logic [3:0] old;
    repeat (n)
    begin
      @(posedge CLOCK_I);
      old = m_video();
      WIN_ACT_I <= 1'($urandom);
      WIN_COLOR_I <= 3'($urandom);
      WIN_SHADOW_I <= 4'($urandom);
      EDGE_I <= 1'($urandom) & hi[1];
      CHAR_LUM_I <= 1'($urandom) & hi[0];
      CHAR_COLOR_I <= 3'($urandom);
      repeat (lat - 1) @(posedge CLOCK_I);
      @(negedge CLOCK_I);
      check("early", {12'h0, old}, {12'h0, FAST_BLANK_O, RGB_O});
      repeat (12) @(posedge CLOCK_I);
      @(negedge CLOCK_I);
      check("video", {12'h0, m_video()}, {12'h0, FAST_BLANK_O, RGB_O});
    end
  endtask

  initial
  begin
    foreach (m_main[i]) m_main[i] = 8'h00;
    foreach (m_ext[i]) m_ext[i] = 8'h00;
    void'($urandom(9));
    repeat (10) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    @(negedge CLOCK_I);
    chk_all();
    vid(4, 2'b11);
    $display("test reset done");
    wr(ROW_MAIN, COL_DISP_CTRL, 8'h00);
    for (int w = 0; w < 3; w++)
      wr(ROW_MAIN, 8'(1 + 3 * w), 8'h02);
    wr(ROW_MAIN, COL_SHADOW_W, 8'he4);
    wr(ROW_MAIN, COL_SHADOW_H, 8'h1b);
    chk_all();
    wr(ROW_MAIN, COL_WIN4_CTRL, 8'h02);
    chk_all();
    wr(ROW_MAIN, COL_SHADOW_W, 8'($urandom));
    wr(ROW_MAIN, COL_SHADOW_H, 8'($urandom));
    chk_all();
    $display("test shadow size done");
    wr(ROW_EXT, COL_SHADOW_CA, 8'($urandom) & 8'h77);
    wr(ROW_EXT, COL_SHADOW_CB, 8'($urandom) & 8'h77);
    wr(ROW_MAIN, COL_EDGE_COLOR, 8'($urandom) & 8'h07);
    vid(16, 2'b00);
    vid(16, 2'b11);
    $display("test colour done");
    wr(ROW_MAIN, COL_SELFTEST, 8'h80 | (8'($urandom) & 8'h07));
    vid(8, 2'b11);
    chk_all();
    wr(ROW_MAIN, COL_SELFTEST, 8'h00);
    vid(4, 2'b11);
    $display("test selftest done");
    refuse(ROW_MAIN, COL_RSV_FIRST);
    refuse(ROW_MAIN, 8'h1f);
    refuse(ROW_EXT, COL_RSV_EXT);
    sync_pulse();
    refuse(ROW_MAIN, COL_SHADOW_W);
    wait_hi("pll settled", PLL_SETTLED_O);
    sync_pulse();
    wr(ROW_MAIN, COL_SYNC_CTRL, 8'h00);
    check("vco", 16'h1, {14'h0, VCO_CODE_O});
    $display("test refusal done");
    wr(ROW_EXT, COL_APP_SELECT, {2'b10, KEY_TO_CRT});
    chk_all();
    wr(ROW_EXT, COL_APP_SELECT, {2'b10, KEY_TO_LCD});
    chk_all();
    wr(ROW_EXT, COL_OUT_DELAY, 8'h07);
    vid(4, 2'b11, 9);
    wr(ROW_MAIN, COL_SELFTEST, 8'h85);
    vid(4, 2'b11, 9);
    wr(ROW_EXT, COL_APP_SELECT, {2'b00, KEY_TO_LCD});
    chk_all();
    wr(ROW_EXT, COL_APP_SELECT, {2'b00, KEY_TO_CRT});
    chk_all();
    vid(4, 2'b11);
    $display("test panel mode done");
    end_of_test();
  end
endmodule // osd_shadow_selftest_mode_regs_test
`default_nettype wire
